// ---- src/fpep_consts.svh ----
`ifndef FPEP_CONSTS_SVH
`define FPEP_CONSTS_SVH

`define FPEP_P_BIT       3'd0
`define FPEP_E_BIT       3'd1
`define FPEP_PV_BIT      3'd2
`define FPEP_EV_BIT      3'd3
`define FPEP_SWE_BIT     3'd7
`define FPEP_FLASH_ERROR_FLAG_BIT    3'd7
`define FPEP_SUBACTIVE_POWERDOWN_DISABLE_BIT   3'd7
`define FPEP_PRI_MASK    8'h8F
`define FPEP_PRI_RST     8'h00
`define FPEP_EBS_RST     8'h00
`define FPEP_PWR_RST     8'h00
`define FPEP_CLK_MHZ     125
`define FPEP_WAIT_US     20
`define FPEP_WAIT_CYC    (`FPEP_WAIT_US * `FPEP_CLK_MHZ)
`define FPEP_CNT_W       16

`endif

// ---- src/fpep_pkg.sv ----
`default_nettype none
package fpep_pkg;
    typedef enum logic [2:0] {
        MODE_ACTIVE,
        MODE_SLEEP,
        MODE_SUBACTIVE,
        MODE_SUBSLEEP,
        MODE_STANDBY
    } fpep_mode_e;

    typedef enum logic [1:0] {
        SEL_PRIMARY,
        SEL_SECONDARY,
        SEL_ERASE_BLOCK,
        SEL_POWER
    } fpep_reg_e;

    typedef enum logic [1:0] {
        FS_NORMAL,
        FS_POWERDOWN,
        FS_STANDBY,
        FS_RECOVER
    } fpep_fstate_e;
endpackage : fpep_pkg
`default_nettype wire

// ---- src/fpep_wait_if.sv ----
`default_nettype none
interface fpep_wait_if;
    logic       start;
    logic [2:0] sel;
    logic       done;
    modport ctrl  (output start, output sel, input done);
    modport timer (input start, input sel, output done);
endinterface : fpep_wait_if
`default_nettype wire

// ---- src/fpep_wait.sv ----
`include "fpep_consts.svh"
`default_nettype none
module fpep_wait #(
    parameter int UNIT_CYC = `FPEP_WAIT_CYC
) (
    input wire logic    clock,
    input wire logic    clk_en,
    input wire logic    rst_b,
    fpep_wait_if.timer  wt
);
    logic [`FPEP_CNT_W-1:0] cnt_r;
    logic                   done_r;

    // Each select step adds one full minimum period, so no code gives less
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= '0;
        end else if (clk_en) begin
            if (wt.start) begin
                cnt_r <= `FPEP_CNT_W'(UNIT_CYC * (int'(wt.sel) + 1));
            end else if (cnt_r != '0) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            done_r <= 1'b0;
        end else if (clk_en) begin
            done_r <= !wt.start && (cnt_r == `FPEP_CNT_W'(1));
        end
    end

    assign wt.done = done_r;
endmodule : fpep_wait
`default_nettype wire

// ---- src/fpep_top.sv ----
`include "fpep_consts.svh"
`default_nettype none
module fpep_top
    import fpep_pkg::*;
#(
    parameter int WAIT_UNIT_CYC = `FPEP_WAIT_CYC
) (
    input  wire logic         clock,
    input  wire logic         clk_en,
    input  wire logic         rst_b,
    input  wire logic         external_reset_pin_b,
    input  wire logic         sys_reset_req,
    input  wire fpep_mode_e   op_mode,
    input  wire logic [2:0]   standby_wait_select,
    input  wire logic         reg_wr_en,
    input  wire fpep_reg_e    reg_wr_sel,
    input  wire logic [7:0]   reg_wr_data,
    input  wire logic         flash_read_strobe,
    input  wire logic         exception_start,
    input  wire logic         sleep_exec,
    output logic [7:0]        flash_mode_control_primary,
    output logic [7:0]        flash_mode_control_secondary,
    output logic [7:0]        erase_block_select,
    output logic [7:0]        flash_power_control,
    output logic              program_pulse,
    output logic [7:0]        erase_stress,
    output logic              program_verify_mode,
    output logic              erase_verify_mode,
    output logic              error_protect,
    output fpep_fstate_e      flash_state,
    output logic              flash_read_allowed
);
    function automatic logic is_low_power(input fpep_mode_e m);
        is_low_power = (m == MODE_SUBACTIVE) || (m == MODE_SUBSLEEP) ||
                       (m == MODE_STANDBY);
    endfunction : is_low_power

    function automatic logic wr_hit(input logic en, input fpep_reg_e s, input fpep_reg_e t);
        wr_hit = en && (s == t);
    endfunction : wr_hit

    logic          pin_sync1_r;
    logic          pin_sync2_r;
    logic [7:0]    pri_r;
    logic [7:0]    pri_nxt;
    logic [7:0]    ebs_r;
    logic [7:0]    ebs_nxt;
    logic [7:0]    pwr_r;
    logic          err_r;
    logic          pulse_r;
    logic [7:0]    stress_r;
    logic          pv_mode_r;
    logic          ev_mode_r;
    logic          rd_ok_r;
    fpep_fstate_e  fs_r;
    fpep_fstate_e  fs_nxt;
    fpep_fstate_e  fs_target;
    logic          hw_prot;
    logic          busy;
    logic          err_evt;
    logic          software_write_enable;
    fpep_wait_if   wif ();

    // Pin is asynchronous to clock
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pin_sync1_r <= 1'b0;
            pin_sync2_r <= 1'b0;
        end else if (clk_en) begin
            pin_sync1_r <= external_reset_pin_b;
            pin_sync2_r <= pin_sync1_r;
        end
    end

    assign hw_prot = !pin_sync2_r || sys_reset_req || is_low_power(op_mode);
    assign software_write_enable     = pri_r[`FPEP_SWE_BIT];
    assign busy    = pulse_r || (stress_r != 8'h00);
    assign ebs_nxt = wr_hit(reg_wr_en, reg_wr_sel, SEL_ERASE_BLOCK) ? reg_wr_data : ebs_r;
    assign err_evt = busy && (flash_read_strobe || exception_start || sleep_exec);

    // Program/erase bits land only when write enable is already on
    always_comb begin
        pri_nxt = pri_r;
        if (wr_hit(reg_wr_en, reg_wr_sel, SEL_PRIMARY)) begin
            pri_nxt = reg_wr_data & `FPEP_PRI_MASK;
            if (!software_write_enable) begin
                pri_nxt[`FPEP_P_BIT] = 1'b0;
                pri_nxt[`FPEP_E_BIT] = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pri_r <= `FPEP_PRI_RST;
        end else if (clk_en) begin
            if (hw_prot) begin
                pri_r <= `FPEP_PRI_RST;
            end else if (!err_evt) begin
                pri_r <= pri_nxt;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ebs_r <= `FPEP_EBS_RST;
        end else if (clk_en) begin
            if (hw_prot) begin
                ebs_r <= `FPEP_EBS_RST;
            end else if (!err_evt && wr_hit(reg_wr_en, reg_wr_sel, SEL_ERASE_BLOCK)) begin
                ebs_r <= reg_wr_data;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pwr_r <= `FPEP_PWR_RST;
        end else if (clk_en && wr_hit(reg_wr_en, reg_wr_sel, SEL_POWER)) begin
            pwr_r <= reg_wr_data & (8'h01 << `FPEP_SUBACTIVE_POWERDOWN_DISABLE_BIT);
        end
    end

    // Flag has no software write path; rst_b is the power-on reset
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            err_r <= 1'b0;
        end else if (clk_en && err_evt) begin
            err_r <= 1'b1;
        end
    end

    // Mode drops in the same edge that records the error
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pulse_r  <= 1'b0;
            stress_r <= 8'h00;
        end else if (clk_en) begin
            pulse_r  <= pri_r[`FPEP_P_BIT] && software_write_enable && !err_r && !err_evt && !hw_prot;
            stress_r <= (pri_r[`FPEP_E_BIT] && software_write_enable && !err_r && !err_evt && !hw_prot)
                        ? (ebs_r & ebs_nxt) : 8'h00;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pv_mode_r <= 1'b0;
            ev_mode_r <= 1'b0;
        end else if (clk_en) begin
            pv_mode_r <= pri_r[`FPEP_PV_BIT] && !hw_prot;
            ev_mode_r <= pri_r[`FPEP_EV_BIT] && !hw_prot;
        end
    end

    always_comb begin
        case (op_mode)
            MODE_ACTIVE, MODE_SLEEP: fs_target = FS_NORMAL;
            MODE_SUBACTIVE: fs_target = pwr_r[`FPEP_SUBACTIVE_POWERDOWN_DISABLE_BIT] ? FS_NORMAL : FS_POWERDOWN;
            default: fs_target = FS_STANDBY;
        endcase
    end

    always_comb begin
        fs_nxt    = fs_r;
        wif.start = 1'b0;
        case (fs_r)
            FS_NORMAL: begin
                fs_nxt = fs_target;
            end
            FS_POWERDOWN, FS_STANDBY: begin
                fs_nxt = fs_target;
                if (fs_target == FS_NORMAL) begin
                    fs_nxt    = FS_RECOVER;
                    wif.start = 1'b1;
                end
            end
            FS_RECOVER: begin
                if (fs_target != FS_NORMAL) begin
                    fs_nxt = fs_target;
                end else if (wif.done) begin
                    fs_nxt = FS_NORMAL;
                end
            end
            default: fs_nxt = FS_STANDBY;
        endcase
    end

    assign wif.sel = standby_wait_select;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fs_r    <= FS_NORMAL;
            rd_ok_r <= 1'b1;
        end else if (clk_en) begin
            fs_r    <= fs_nxt;
            rd_ok_r <= (fs_nxt == FS_NORMAL) || (fs_nxt == FS_POWERDOWN);
        end
    end

    fpep_wait #(
        .UNIT_CYC (WAIT_UNIT_CYC)
    ) u_wait (
        .clock  (clock),
        .clk_en (clk_en),
        .rst_b  (rst_b),
        .wt     (wif.timer)
    );

    assign flash_mode_control_primary   = pri_r;
    assign flash_mode_control_secondary = {err_r, 7'h00};
    assign erase_block_select           = ebs_r;
    assign flash_power_control          = pwr_r;
    assign program_pulse                = pulse_r;
    assign erase_stress                 = stress_r;
    assign program_verify_mode          = pv_mode_r;
    assign erase_verify_mode            = ev_mode_r;
    assign error_protect                = err_r;
    assign flash_state                  = fs_r;
    assign flash_read_allowed           = rd_ok_r;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    sequence s_err_event;
        clk_en && err_evt;
    endsequence
    sequence s_stopped;
        !program_pulse && (erase_stress == 8'h00);
    endsequence
    sequence s_leave_low;
        clk_en && (fs_r == FS_RECOVER) && !wif.done && (fs_target == FS_NORMAL);
    endsequence

    property p_hw_clear;
        clk_en && hw_prot |=> ((pri_r == 8'h00) && (ebs_r == 8'h00)) and s_stopped;
    endproperty
    a_hw_clear: assert property (p_hw_clear) else $error("protection did not clear");

    property p_swe_block;
        clk_en && !software_write_enable |=> !program_pulse && (erase_stress == 8'h00);
    endproperty
    a_swe_block: assert property (p_swe_block) else $error("mode entered without enable");

    property p_erase_sel;
        (erase_stress & ~erase_block_select) == 8'h00;
    endproperty
    a_erase_sel: assert property (p_erase_sel) else $error("unselected block erased");

    property p_err_abort;
        s_err_event |=> error_protect ##0 s_stopped;
    endproperty
    a_err_abort: assert property (p_err_abort) else $error("error not caught");

    property p_err_sticky;
        error_protect |=> error_protect;
    endproperty
    a_err_sticky: assert property (p_err_sticky) else $error("error flag cleared");

    property p_err_refuse;
        error_protect |-> s_stopped;
    endproperty
    a_err_refuse: assert property (p_err_refuse) else $error("mode under error");

    property p_err_keep;
        s_err_event ##0 !hw_prot |=> (pri_r == $past(pri_r)) && (ebs_r == $past(ebs_r));
    endproperty
    a_err_keep: assert property (p_err_keep) else $error("settings lost on error");

    property p_prog_cause;
        clk_en && !pri_r[`FPEP_P_BIT] |=> !program_pulse;
    endproperty
    a_prog_cause: assert property (p_prog_cause) else $error("pulse without bit");

    property p_standby;
        clk_en && ((op_mode == MODE_SUBSLEEP) || (op_mode == MODE_STANDBY))
            |=> flash_state == FS_STANDBY;
    endproperty
    a_standby: assert property (p_standby) else $error("standby not entered");

    property p_wait_held;
        s_leave_low |=> flash_state == FS_RECOVER;
    endproperty
    a_wait_held: assert property (p_wait_held) else $error("recovery cut short");
endmodule : fpep_top
`default_nettype wire

// ---- verification/fpep_cpu_model.sv ----
`default_nettype none
module fpep_cpu_model
    import fpep_pkg::*;
(
    input  wire logic       clock,
    output var  logic       reg_wr_en,
    output var  fpep_reg_e  reg_wr_sel,
    output var  logic [7:0] reg_wr_data,
    output var  logic       flash_read_strobe,
    output var  logic       exception_start,
    output var  logic       sleep_exec
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_wr_en = 1'b0;
        reg_wr_sel = SEL_PRIMARY;
        reg_wr_data = 8'h00;
        flash_read_strobe = 1'b0;
        exception_start = 1'b0;
        sleep_exec = 1'b0;
    end
    // Caller sets write enable before program or erase bits
    task automatic wr(input fpep_reg_e sel, input logic [7:0] d);
        @(posedge clock);
        reg_wr_en <= 1'b1;
        reg_wr_sel <= sel;
        reg_wr_data <= d;
        @(posedge clock);
        reg_wr_en <= 1'b0;
        // Idle data bus shows junk, not the last value
        reg_wr_data <= ~d;
    endtask : wr
    // One-cycle error source: 0 read, 1 exception, 2 sleep
    task automatic hit(input int k);
        @(posedge clock);
        flash_read_strobe <= (k == 0);
        exception_start <= (k == 1);
        sleep_exec <= (k == 2);
        @(posedge clock);
        flash_read_strobe <= 1'b0;
        exception_start <= 1'b0;
        sleep_exec <= 1'b0;
    endtask : hit
endmodule : fpep_cpu_model
`default_nettype wire

// ---- verification/fpep_top_bench.sv ----
`default_nettype none
module fpep_top_bench
    import fpep_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WU = 4;
    typedef struct packed {
        logic       software_write_enable;
        logic [7:0] pri;
        logic [7:0] ebs;
        logic [7:0] xpri;
        logic       xpp;
        logic [7:0] xst;
    } fpep_row_s;
    fpep_row_s rows [0:4] = '{
        '{1'b1, 8'h81, 8'h01, 8'h81, 1'b1, 8'h00},
        '{1'b1, 8'h82, 8'h04, 8'h82, 1'b0, 8'h04},
        '{1'b1, 8'h82, 8'h00, 8'h82, 1'b0, 8'h00},
        '{1'b0, 8'h02, 8'h08, 8'h00, 1'b0, 8'h00},
        '{1'b0, 8'h83, 8'h08, 8'h80, 1'b0, 8'h00}
    };
    fpep_mode_e   hw_md [0:2] = '{MODE_SUBACTIVE, MODE_SUBSLEEP, MODE_STANDBY};
    fpep_fstate_e x_fs [0:4] = '{FS_POWERDOWN, FS_STANDBY, FS_STANDBY, FS_NORMAL, FS_NORMAL};
    logic         clock = 1'b0;
    logic         rst_b = 1'b0;
    logic         clk_en = 1'b1;
    logic         pin_b = 1'b1;
    logic         sys_rq = 1'b0;
    fpep_mode_e   op_mode = MODE_ACTIVE;
    logic [2:0]   wsel = 3'h1;
    logic         we, rd, exc, slp, pp, pvm, evm, errp, rda;
    fpep_reg_e    wsl;
    logic [7:0]   wd, pri, sec, ebs, pwr, stress;
    fpep_fstate_e fst;
    int           n_fail = 0;
    int           cmp_count = 0;
    int           n;
    always #4 clock = ~clock;
    fpep_top #(.WAIT_UNIT_CYC(WU)) u_dut (
        .clock(clock), .clk_en(clk_en), .rst_b(rst_b),
        .external_reset_pin_b(pin_b), .sys_reset_req(sys_rq), .op_mode(op_mode),
        .standby_wait_select(wsel), .reg_wr_en(we), .reg_wr_sel(wsl),
        .reg_wr_data(wd), .flash_read_strobe(rd), .exception_start(exc),
        .sleep_exec(slp), .flash_mode_control_primary(pri),
        .flash_mode_control_secondary(sec), .erase_block_select(ebs),
        .flash_power_control(pwr), .program_pulse(pp), .erase_stress(stress),
        .program_verify_mode(pvm), .erase_verify_mode(evm), .error_protect(errp),
        .flash_state(fst), .flash_read_allowed(rda)
    );
    fpep_cpu_model u_cpu (
        .clock(clock), .reg_wr_en(we), .reg_wr_sel(wsl), .reg_wr_data(wd),
        .flash_read_strobe(rd), .exception_start(exc), .sleep_exec(slp)
    );
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("counts: compares=%0d mismatches=%0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up
    task automatic settle(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : settle
    // Synchroniser holds protection two edges after release
    task automatic do_reset;
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        settle(3);
    endtask : do_reset
    task automatic arm(input logic [7:0] p, input logic [7:0] b);
        u_cpu.wr(SEL_ERASE_BLOCK, b);
        u_cpu.wr(SEL_PRIMARY, 8'h80);
        u_cpu.wr(SEL_PRIMARY, p);
        settle(2);
    endtask : arm
    initial begin
        do_reset();
        check(pri, 8'h00);
        check(sec, 8'h00);
        check(ebs, 8'h00);
        check(fst, FS_NORMAL);
        check(rda, 1'b1);
        $display("test reset done");
        foreach (rows[i]) begin
            u_cpu.wr(SEL_ERASE_BLOCK, rows[i].ebs);
            if (rows[i].software_write_enable) begin
                u_cpu.wr(SEL_PRIMARY, 8'h80);
            end
            u_cpu.wr(SEL_PRIMARY, rows[i].pri);
            settle(2);
            check(pri, rows[i].xpri);
            check(ebs, rows[i].ebs);
            check(pp, rows[i].xpp);
            check(stress, rows[i].xst);
            u_cpu.wr(SEL_PRIMARY, 8'h00);
            $display("test row %0d done", i);
        end
        arm(8'h82, 8'h04);
        check(stress, 8'h04);
        u_cpu.wr(SEL_ERASE_BLOCK, 8'h00);
        settle(0);
        check(stress, 8'h00);
        check(ebs, 8'h00);
        u_cpu.wr(SEL_PRIMARY, 8'h00);
        $display("test deselect during erase done");
        for (int k = 0; k < 3; k++) begin
            do_reset();
            u_cpu.hit(k);
            settle(1);
            check(errp, 1'b0);
            arm((k == 1) ? 8'h82 : 8'h81, 8'h01);
            u_cpu.hit(k);
            settle(1);
            check(errp, 1'b1);
            check(sec, 8'h80);
            check(pp, 1'b0);
            check(stress, 8'h00);
            check(pri, (k == 1) ? 8'h82 : 8'h81);
            $display("test error source %0d done", k);
        end
        u_cpu.wr(SEL_PRIMARY, 8'h81);
        settle(2);
        check(pp, 1'b0);
        u_cpu.wr(SEL_PRIMARY, 8'h8C);
        settle(2);
        check(pvm, 1'b1);
        check(evm, 1'b1);
        u_cpu.wr(SEL_SECONDARY, 8'h00);
        settle(1);
        check(sec, 8'h80);
        @(posedge clock);
        sys_rq <= 1'b1;
        settle(2);
        @(posedge clock);
        sys_rq <= 1'b0;
        settle(1);
        check(pri, 8'h00);
        check(pvm, 1'b0);
        check(evm, 1'b0);
        check(errp, 1'b1);
        do_reset();
        check(errp, 1'b0);
        $display("test error protection done");
        for (int k = 0; k < 5; k++) begin
            arm(8'h82, 8'h02);
            @(posedge clock);
            if (k < 3) begin
                op_mode <= hw_md[k];
            end else if (k == 3) begin
                sys_rq <= 1'b1;
            end else begin
                pin_b <= 1'b0;
            end
            settle(4);
            check(pri, 8'h00);
            check(ebs, 8'h00);
            check(stress, 8'h00);
            check(fst, x_fs[k]);
            check(rda, (k == 1 || k == 2) ? 1'b0 : 1'b1);
            @(posedge clock);
            op_mode <= MODE_ACTIVE;
            sys_rq <= 1'b0;
            pin_b <= 1'b1;
            n = 0;
            while (fst !== FS_NORMAL && n < 100) begin
                settle(1);
                n++;
            end
            if (n == 100) begin
                n_fail++;
                wrap_up();
            end
            if (k < 3) begin
                check(n >= 2 * WU && n <= 2 * WU + 4, 1'b1);
            end
            $display("test protection cause %0d done", k);
        end
        u_cpu.wr(SEL_POWER, 8'h80);
        @(posedge clock);
        op_mode <= MODE_SUBACTIVE;
        settle(3);
        check(pwr, 8'h80);
        check(fst, FS_NORMAL);
        @(posedge clock);
        op_mode <= MODE_SUBSLEEP;
        settle(3);
        check(fst, FS_STANDBY);
        @(posedge clock);
        op_mode <= MODE_SLEEP;
        settle(20);
        check(fst, FS_NORMAL);
        $display("test power states done");
        arm(8'h81, 8'h01);
        @(posedge clock);
        clk_en  <= 1'b0;
        op_mode <= MODE_STANDBY;
        settle(4);
        check(pp, 1'b1);
        check(fst, FS_NORMAL);
        @(posedge clock);
        clk_en <= 1'b1;
        settle(2);
        check(pp, 1'b0);
        check(fst, FS_STANDBY);
        $display("test clock enable done");
        wrap_up();
    end
    // Guard against a hang anywhere in the sequence
    initial begin
        #400000;
        n_fail++;
        wrap_up();
    end
endmodule : fpep_top_bench
`default_nettype wire
